// file: pkg/rx_ctrl_pkg.sv
// constants for the per-channel receive control register bank
package rx_ctrl_pkg;
  localparam int CHANNELS = 12;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CTRL_W = 6;
  localparam int CH_IDX_W = 4;
  // address layout: upper nibble picks the channel, lower nibble the register
  localparam logic [3:0] RX_CTRL_LOW = 4'h5;
  localparam logic [3:0] LOW_BANK_LAST = 4'h5;
  localparam logic [3:0] HIGH_BANK_FIRST = 4'h8;
  localparam logic [3:0] HIGH_BANK_LAST = 4'hD;
  localparam logic [3:0] HIGH_BANK_SKIP = 4'h2;
  // field positions
  localparam int EQ_ENABLE_BIT = 0;
  localparam int MONITOR_BIT = 1;
  localparam int MUTE_BIT = 2;
  localparam int EDGE_SEL_BIT = 3;
  localparam int ANA_DISABLE_BIT = 4;
  localparam int DIG_DISABLE_BIT = 5;
  localparam logic [DATA_W-CTRL_W-1:0] RESERVED_READ = 2'h0;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
endpackage : rx_ctrl_pkg

// file: pkg/rx_chan_if.sv
// control and status carrier between the register bank and one channel
`timescale 1ns/100ps
interface rx_chan_if;
  logic digDisable;
  logic anaDisable;
  logic edgeSel;
  logic mute;
  logic monitor;
  logic e3Mode;
  logic lossDeclared;
  modport ctrl (output digDisable, anaDisable, edgeSel, mute, monitor, e3Mode, input lossDeclared);
  modport chan (input digDisable, anaDisable, edgeSel, mute, monitor, e3Mode, output lossDeclared);
endinterface : rx_chan_if

// file: hw/rx_channel_datapath.sv
// one channel: signal-loss declaration, muting and recovered-data launch edge
`timescale 1ns/100ps
module rx_channel_datapath (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // settings from the register bank
  rx_chan_if.chan ctl,
  // line side inputs, asynchronous to mclk
  input wire logic lineClk,
  input wire logic linePos,
  input wire logic lineNeg,
  input wire logic digLossRaw,
  input wire logic anaLossRaw,
  // recovered outputs
  output logic rxPositiveDataOut,
  output logic rxNegativeDataOut,
  output logic rxRecoveredClockOut
);
  import rx_ctrl_pkg::*;

  typedef struct packed {
    logic [2:0] clkS;
    logic [1:0] posS;
    logic [1:0] negS;
    logic [1:0] digS;
    logic [1:0] anaS;
    logic loss;
    logic pos;
    logic neg;
    logic clk;
  } chan_state_type;

  chan_state_type st_r, st_nxt;
  logic digOn, anaOn, lossNow, riseEdge, fallEdge, launch;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  // stage [0] of every synchroniser feeds stage [1] only
  always_comb begin
    st_nxt = st_r;
    st_nxt.clkS = {st_r.clkS[1:0], lineClk};
    st_nxt.posS = {st_r.posS[0], linePos};
    st_nxt.negS = {st_r.negS[0], lineNeg};
    st_nxt.digS = {st_r.digS[0], digLossRaw};
    st_nxt.anaS = {st_r.anaS[0], anaLossRaw};
    // disables only count outside E3; in E3 the detectors stay on
    digOn = ~ctl.digDisable | ctl.e3Mode;
    anaOn = ~ctl.anaDisable | ctl.e3Mode;
    // monitor mode suppresses every declaration
    lossNow = ~ctl.monitor & ((st_r.digS[1] & digOn) | (st_r.anaS[1] & anaOn));
    st_nxt.loss = lossNow;
    riseEdge = ~st_r.clkS[2] & st_r.clkS[1];
    fallEdge = st_r.clkS[2] & ~st_r.clkS[1];
    launch = ctl.edgeSel ? fallEdge : riseEdge;
    // clock out moves on the same edge as the data, so edge relation holds
    st_nxt.clk = st_r.clkS[1];
    if (ctl.mute && lossNow) begin
      st_nxt.pos = 1'b0;
      st_nxt.neg = 1'b0;
    end else if (launch) begin
      st_nxt.pos = st_r.posS[1];
      st_nxt.neg = st_r.negS[1];
    end
  end

  // state register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ctl.lossDeclared = st_r.loss;
  assign rxPositiveDataOut = st_r.pos;
  assign rxNegativeDataOut = st_r.neg;
  assign rxRecoveredClockOut = st_r.clk;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  monitor_no_loss_a: assert property (ctl.monitor |=> !st_r.loss) else $error("loss declared in monitor mode");
  mute_holds_low_a: assert property (st_r.loss && $past(ctl.mute) |-> !st_r.pos && !st_r.neg) else $error("data not muted");
  e3_ignores_a: assert property (ctl.e3Mode && !ctl.monitor && st_r.digS[1] |=> st_r.loss) else $error("e3 loss lost");
  dig_disabled_a: assert property (!ctl.e3Mode && ctl.digDisable && !st_r.anaS[1] |=> !st_r.loss) else $error("digital on");
  ana_disabled_a: assert property (!ctl.e3Mode && ctl.anaDisable && !st_r.digS[1] |=> !st_r.loss) else $error("analog on");
  rise_launch_a: assert property (!ctl.edgeSel && !ctl.mute && riseEdge |=> st_r.pos == $past(st_r.posS[1])) else $error("rise launch");
  fall_launch_a: assert property (ctl.edgeSel && !ctl.mute && fallEdge |=> st_r.neg == $past(st_r.negS[1])) else $error("fall launch");

  mute_seen_c: cover property (ctl.mute && st_r.loss);
  monitor_seen_c: cover property (ctl.monitor && st_r.digS[1]);
  fall_seen_c: cover property (ctl.edgeSel && fallEdge);
endmodule : rx_channel_datapath

// file: hw/rx_channel_control_register.sv
// receive control register bank for all channels, on the microprocessor port
`timescale 1ns/100ps
module rx_channel_control_register #(
  parameter int CH_COUNT = rx_ctrl_pkg::CHANNELS
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // microprocessor port, strobes active low
  input wire logic csN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic [rx_ctrl_pkg::ADDR_W-1:0] addr,
  input wire logic [rx_ctrl_pkg::DATA_W-1:0] dataIn,
  output logic [rx_ctrl_pkg::DATA_W-1:0] dataOut,
  output logic dataOe,
  // per-channel rate, from the channel control logic
  input wire logic [CH_COUNT-1:0] e3Mode,
  // per-channel line inputs
  input wire logic [CH_COUNT-1:0] lineClk,
  input wire logic [CH_COUNT-1:0] linePos,
  input wire logic [CH_COUNT-1:0] lineNeg,
  input wire logic [CH_COUNT-1:0] digLossRaw,
  input wire logic [CH_COUNT-1:0] anaLossRaw,
  // per-channel outputs
  output logic [CH_COUNT-1:0] rxPositiveDataOut,
  output logic [CH_COUNT-1:0] rxNegativeDataOut,
  output logic [CH_COUNT-1:0] rxRecoveredClockOut,
  output logic [CH_COUNT-1:0] signalLossDeclared,
  output logic [CH_COUNT-1:0] equalizerEnable
);
  import rx_ctrl_pkg::*;

  typedef struct packed {
    logic [1:0] csS;
    logic [1:0] rdS;
    logic [2:0] wrS;
    logic [1:0][ADDR_W-1:0] addrS;
    logic [1:0][DATA_W-1:0] dataS;
    logic [CH_COUNT-1:0][CTRL_W-1:0] ctrl;
    logic [DATA_W-1:0] rdData;
    logic rdOe;
  } bank_state_type;

  bank_state_type st_r, st_nxt;
  logic [CH_IDX_W:0] dec;
  logic wrHit, rdActive;

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  // returns {hit, channel}; the two banks leave a gap at nibbles 6 and 7
  // the upper bank is shifted down so channel numbers stay contiguous
  // a channel count below twelve turns every channel number from that count upward into a hole
  function automatic logic [CH_IDX_W:0] chanOf(input logic [ADDR_W-1:0] a);
    logic [3:0] hi;
    logic [3:0] ch;
    logic hit;
    hi = a[ADDR_W-1:ADDR_W-4];
    ch = hi;
    hit = 1'b0;
    if (a[3:0] == RX_CTRL_LOW) begin
      if (hi <= LOW_BANK_LAST) begin
        hit = 1'b1;
      end else if (hi >= HIGH_BANK_FIRST && hi <= HIGH_BANK_LAST) begin
        hit = 1'b1;
        ch = hi - HIGH_BANK_SKIP;
      end
    end
    if (32'(ch) >= CH_COUNT) begin
      hit = 1'b0;
    end
    return {hit, ch};
  endfunction : chanOf

  // --------------------------------------------------------------------------
  // bus port and register storage
  // --------------------------------------------------------------------------
  // strobes, address and data pass two flops; address and data must hold
  // through the strobe, so the second stage is settled when it is used
  // the write strobe needs one sampled high cycle between writes or a falling edge is lost
  always_comb begin
    st_nxt = st_r;
    st_nxt.csS = {st_r.csS[0], csN};
    st_nxt.rdS = {st_r.rdS[0], rdN};
    st_nxt.wrS = {st_r.wrS[1:0], wrN};
    st_nxt.addrS = {st_r.addrS[0], addr};
    st_nxt.dataS = {st_r.dataS[0], dataIn};
    dec = chanOf(st_r.addrS[1]);
    // one write per falling edge of the write strobe
    // the reserved pair is not stored, so it reads back as a constant
    wrHit = ~st_r.csS[1] & st_r.wrS[2] & ~st_r.wrS[1];
    if (wrHit && dec[CH_IDX_W]) begin
      st_nxt.ctrl[dec[CH_IDX_W-1:0]] = st_r.dataS[1][CTRL_W-1:0];
    end
    // reads drive the data bus for as long as chip select and read are low
    rdActive = ~st_r.csS[1] & ~st_r.rdS[1];
    st_nxt.rdOe = rdActive;
    st_nxt.rdData = UNMAPPED_READ;
    if (rdActive && dec[CH_IDX_W]) begin
      st_nxt.rdData = {RESERVED_READ, st_r.ctrl[dec[CH_IDX_W-1:0]]};
    end
  end

  // state register
  // sync stages reset to the idle level of their pins, so no false strobe edge follows reset
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_r.csS <= '1;
      st_r.rdS <= '1;
      st_r.wrS <= '1;
      st_r.addrS <= '0;
      st_r.dataS <= '0;
      st_r.ctrl <= {CH_COUNT{CTRL_RESET}};
      st_r.rdData <= UNMAPPED_READ;
      st_r.rdOe <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dataOut = st_r.rdData;
  assign dataOe = st_r.rdOe;

  // --------------------------------------------------------------------------
  // channels
  // --------------------------------------------------------------------------
  // each channel gets its own carrier; rate comes from outside the bank
  // recovered clock and data leave about three cycles after the line pins move
  for (genvar i = 0; i < CH_COUNT; i++) begin : gChan
    rx_chan_if link ();
    assign link.digDisable = st_r.ctrl[i][DIG_DISABLE_BIT];
    assign link.anaDisable = st_r.ctrl[i][ANA_DISABLE_BIT];
    assign link.edgeSel = st_r.ctrl[i][EDGE_SEL_BIT];
    assign link.mute = st_r.ctrl[i][MUTE_BIT];
    assign link.monitor = st_r.ctrl[i][MONITOR_BIT];
    assign link.e3Mode = e3Mode[i];
    assign signalLossDeclared[i] = link.lossDeclared;
    assign equalizerEnable[i] = st_r.ctrl[i][EQ_ENABLE_BIT];
    rx_channel_datapath uChan (
      .mclk(mclk),
      .reset_n(reset_n),
      .ctl(link),
      .lineClk(lineClk[i]),
      .linePos(linePos[i]),
      .lineNeg(lineNeg[i]),
      .digLossRaw(digLossRaw[i]),
      .anaLossRaw(anaLossRaw[i]),
      .rxPositiveDataOut(rxPositiveDataOut[i]),
      .rxNegativeDataOut(rxNegativeDataOut[i]),
      .rxRecoveredClockOut(rxRecoveredClockOut[i])
    );
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // a decoded write lands in the addressed channel one cycle later
  write_stores_a: assert property (wrHit && dec[CH_IDX_W] |=>
    st_r.ctrl[$past(dec[CH_IDX_W-1:0])] == $past(st_r.dataS[1][CTRL_W-1:0])) else $error("write lost");
  // a decoded read returns the stored bits with the reserved pair cleared
  read_returns_a: assert property (rdActive && dec[CH_IDX_W] && !wrHit |=>
    st_r.rdData == {RESERVED_READ, $past(st_r.ctrl[dec[CH_IDX_W-1:0]])}) else $error("bad readback");
  unmapped_zero_a: assert property (!dec[CH_IDX_W] |=> st_r.rdData == UNMAPPED_READ) else $error("unmapped read");
  // a read of a hole still drives the bus, with the idle value
  hole_read_a: assert property (rdActive && !dec[CH_IDX_W] |=>
    dataOe && dataOut == UNMAPPED_READ) else $error("hole read not driven");

  // the bus is driven one cycle after a synchronised read request and released after it
  bus_driven_a: assert property (rdActive |=> dataOe)
    else $error("read not driven");
  bus_idle_a: assert property (!rdActive |=> !dataOe && dataOut == UNMAPPED_READ)
    else $error("bus not idle");
  // nothing but the idle value may show while the bus is not driven
  undriven_idle_a: assert property (!dataOe |-> dataOut == UNMAPPED_READ)
    else $error("data while undriven");
  // reserved bits never read as anything but their fixed value
  reserved_read_a: assert property (dataOut[DATA_W-1:CTRL_W] == RESERVED_READ)
    else $error("reserved bits set");

  // storage only moves on a write, and a write into a hole leaves every channel alone
  no_write_hold_a: assert property (!wrHit |=> $stable(st_r.ctrl))
    else $error("register moved");
  hole_write_a: assert property (wrHit && !dec[CH_IDX_W] |=> $stable(st_r.ctrl))
    else $error("hole write landed");


  write_seen_c: cover property (wrHit && dec[CH_IDX_W]);
  read_seen_c: cover property (rdActive && dec[CH_IDX_W] && dec[CH_IDX_W-1]);

  // --------------------------------------------------------------------------
  // per-channel checks at the pins
  // --------------------------------------------------------------------------
  // these watch the outputs rather than the carrier, so a wiring slip shows up
  for (genvar j = 0; j < CH_COUNT; j++) begin : gChk
    // monitor mode keeps the loss flag down whatever the detectors report
    monitor_pin_a: assert property (st_r.ctrl[j][MONITOR_BIT] |=> !signalLossDeclared[j])
      else $error("loss flag in monitor mode");
    // with muting on, a declared loss forces both data pins low
    mute_pin_a: assert property ($past(st_r.ctrl[j][MUTE_BIT]) && signalLossDeclared[j] |->
      !rxPositiveDataOut[j] && !rxNegativeDataOut[j]) else $error("pin data not muted");
    // a write to this channel sets the equalizer pin from bit 0 of the data
    eq_write_a: assert property (wrHit && dec[CH_IDX_W] && 32'(dec[CH_IDX_W-1:0]) == j |=>
      equalizerEnable[j] == $past(st_r.dataS[1][EQ_ENABLE_BIT])) else $error("equalizer not set");
    // the equalizer pin only moves on a write
    eq_hold_a: assert property (!wrHit |=> $stable(equalizerEnable[j]))
      else $error("equalizer moved");
  end
endmodule : rx_channel_control_register

// file: sim/testbench.sv
// self-checking bench for the receive control register bank
`timescale 1ns/100ps
`define CHK(nm, exp, act) begin nCompared++; if ((act) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, act); end end
module testbench;
  import rx_ctrl_pkg::*;
  logic mclk;
  logic reset_n;
  logic csN, rdN, wrN;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dataIn, dataOut, rdData;
  logic dataOe, rdOe;
  logic [CHANNELS-1:0] e3Mode, lineClk, linePos, lineNeg, digLossRaw, anaLossRaw;
  logic [CHANNELS-1:0] rxPos, rxNeg, rxClk, lossOut, eqOut;
  int miscompares = 0;
  int nCompared = 0;
  logic [9:0] lossTab [8] = '{10'h009, 10'h208, 10'h20B, 10'h005, 10'h104, 10'h107, 10'h02C, 10'h30C};

  rx_channel_control_register dut_u (.mclk(mclk), .reset_n(reset_n), .csN(csN), .rdN(rdN), .wrN(wrN),
    .addr(addr), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .e3Mode(e3Mode),
    .lineClk(lineClk), .linePos(linePos), .lineNeg(lineNeg), .digLossRaw(digLossRaw),
    .anaLossRaw(anaLossRaw), .rxPositiveDataOut(rxPos), .rxNegativeDataOut(rxNeg),
    .rxRecoveredClockOut(rxClk), .signalLossDeclared(lossOut), .equalizerEnable(eqOut));

  // ----------------------------------------
  // clock, watchdog and verdict
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // the whole sequence needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    end_sim();
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // ----------------------------------------
  // port access tasks
  // ----------------------------------------
  // inputs always move 2 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : cyc

  // strobes pass a 2-flop sync, so address and data are held well around them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    dataIn = d;
    csN = 1'b0;
    cyc(2);
    wrN = 1'b0;
    cyc(6);
    wrN = 1'b1;
    csN = 1'b1;
    cyc(4);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic oe);
    addr = a;
    csN = 1'b0;
    cyc(2);
    rdN = 1'b0;
    cyc(5);
    d = dataOut;
    oe = dataOe;
    rdN = 1'b1;
    csN = 1'b1;
    cyc(5);
  endtask : rd

  // channel 0 line: data set first, then the recovered clock level
  task automatic line(input logic c, input logic p);
    linePos[0] = p;
    lineNeg[0] = ~p;
    cyc(3);
    lineClk[0] = c;
    cyc(5);
  endtask : line

  function automatic logic [7:0] chAddr(input int ch);
    logic [3:0] hi;
    hi = (ch < 6) ? 4'(ch) : 4'(ch + 2);
    return {hi, 4'h5};
  endfunction : chAddr

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {csN, rdN, wrN} = 3'b111;
    addr = 8'h00;
    dataIn = 8'h00;
    {e3Mode, lineClk, linePos, lineNeg, digLossRaw, anaLossRaw} = '0;
    reset_n = 1'b0;
    repeat (8) @(posedge mclk);
    #2;
    reset_n = 1'b1;
    cyc(2);
    // every channel: reset value, then full write with reserved bits set, then readback
    for (int ch = 0; ch < CHANNELS; ch++) begin
      rd(chAddr(ch), rdData, rdOe);
      `CHK("reset value", ({RESERVED_READ, CTRL_RESET}), rdData)
      wr(chAddr(ch), 8'hC0 | 8'(ch * 5 + 1));
    end
    for (int ch = 0; ch < CHANNELS; ch++) begin
      rd(chAddr(ch), rdData, rdOe);
      `CHK("readback", 8'(ch * 5 + 1) & 8'h3F, rdData)
      `CHK("read enable", 1'b1, rdOe)
      `CHK("equalizer", logic'((ch * 5 + 1) & 1), eqOut[ch])
    end
    $display("test registers done");
    // writes off the register's low nibble or in holes must not land anywhere
    wr(8'h04, 8'h3E);
    wr(8'h65, 8'h3E);
    wr(8'hE5, 8'h3E);
    rd(8'h05, rdData, rdOe);
    `CHK("ch0 untouched", 8'h01, rdData)
    rd(8'h75, rdData, rdOe);
    `CHK("unmapped read", UNMAPPED_READ, rdData)
    `CHK("hole read driven", 1'b1, rdOe)
    `CHK("bus released", 1'b0, dataOe)
    $display("test unmapped done");
    // loss declaration: table of {setting, digital, analog, e3, expected}
    foreach (lossTab[i]) begin
      wr(8'h05, {2'b00, lossTab[i][9:4]});
      {digLossRaw[0], anaLossRaw[0], e3Mode[0]} = lossTab[i][3:1];
      cyc(6);
      `CHK("loss declared", lossTab[i][0], lossOut[0])
      {digLossRaw[0], anaLossRaw[0], e3Mode[0]} = 3'b000;
      cyc(6);
    end
    $display("test loss done");
    // launch edge, select clear then set; clock output follows the line clock
    wr(8'h05, 8'h00);
    line(1'b1, 1'b1);
    `CHK("pos on rise", 1'b1, rxPos[0])
    `CHK("clock out", 1'b1, rxClk[0])
    line(1'b0, 1'b0);
    `CHK("pos held on fall", 1'b1, rxPos[0])
    line(1'b1, 1'b0);
    `CHK("neg on rise", 1'b1, rxNeg[0])
    wr(8'h05, 8'h08);
    line(1'b0, 1'b1);
    `CHK("pos on fall", 1'b1, rxPos[0])
    line(1'b1, 1'b0);
    `CHK("pos held on rise", 1'b1, rxPos[0])
    line(1'b0, 1'b0);
    `CHK("neg on fall", 1'b1, rxNeg[0])
    $display("test edge done");
    // mute: with loss both data outputs go low, without mute data passes
    wr(8'h05, 8'h04);
    line(1'b1, 1'b1);
    `CHK("no loss data", 1'b1, rxPos[0])
    digLossRaw[0] = 1'b1;
    cyc(6);
    `CHK("muted pair", 2'b00, {rxPos[0], rxNeg[0]})
    wr(8'h05, 8'h00);
    line(1'b0, 1'b1);
    line(1'b1, 1'b1);
    `CHK("loss declared", 1'b1, lossOut[0])
    `CHK("unmuted pass", 1'b1, rxPos[0])
    digLossRaw[0] = 1'b0;
    $display("test mute done");
    // software switches the equalizer on for every channel
    for (int ch = 0; ch < CHANNELS; ch++) wr(chAddr(ch), 8'h01);
    `CHK("equalizer all", {CHANNELS{1'b1}}, eqOut)
    $display("test equalizer done");
    cyc(4);
    end_sim();
  end
endmodule : testbench
